// >>> logic/bcs_pkg.sv
// package: register map, field layout, decoded-line carriers
package bcs_pkg;
  localparam int unsigned BCS_ADDR_W = 8;
  localparam logic [7:0] BCS_OFF_CONTROL = 8'h00;
  localparam logic [7:0] BCS_OFF_STATUS = 8'h04;
  localparam logic [7:0] BCS_OFF_STATIC = 8'h08;
  localparam logic [7:0] BCS_OFF_COMPUTED_JUMP_REGISTER = 8'h0C;
  localparam logic [31:0] BCS_CONTROL_RST = 32'h0000_0000;
  localparam logic [31:0] BCS_CONTROL_WMASK = 32'h0FFF_0000;
  localparam int unsigned BCS_IRQ_LSB = 16;
  localparam int unsigned BCS_FLGIN_LSB = 16;
  localparam int unsigned BCS_FLGDIR_LSB = 20;
  localparam int unsigned BCS_FLGOUT_LSB = 24;
  localparam int unsigned BCS_NPINS = 4;
  localparam int unsigned BCS_NSLOTS = 4;
  localparam int unsigned BCS_SHORT_W = 16;
  localparam logic [31:0] BCS_LINE_STEP = 32'h0000_0004;
  localparam logic [1:0] BCS_RESP_OKAY = 2'h0;
  localparam logic [1:0] BCS_RESP_SLVERR = 2'h2;

  // sequencer operation carried in slot 0
  typedef enum logic [3:0] {
    BCS_OP_NONE = 4'h0,
    BCS_OP_JUMP = 4'h1,
    BCS_OP_CALL = 4'h2,
    BCS_OP_COMPUTED_JUMP_REGISTER = 4'h3,
    BCS_OP_CJCALL = 4'h4,
    BCS_OP_NOP = 4'h5,
    BCS_OP_IDLE = 4'h6,
    BCS_OP_BINV = 4'h7,
    BCS_OP_TRAP = 4'h8,
    BCS_OP_ETRAP = 4'h9
  } bcs_op_t;

  // one decoded instruction line from the pipeline
  typedef struct packed {
    logic valid;
    logic [31:0] pc;
    logic has_cond;
    logic [4:0] cond_sel;
    logic cond_neg;
    logic cond_any_blk;
    logic [3:0] seq_slot;
    bcs_op_t op;
    logic abs_opt;
    logic np_opt;
    logic [15:0] imm_lo;
    logic ext_in_slot1;
    logic [15:0] imm_hi;
    logic [3:0] marked;
  } bcs_line_t;

  // line outcome toward the pipeline
  typedef struct packed {
    logic valid;
    logic bad_line;
    logic cond_true;
    logic branch;
    logic [31:0] target;
    logic predicted;
    logic [3:0] slot_exec;
    logic idle;
    logic binv;
    logic trap;
    logic etrap;
  } bcs_result_t;
endpackage

// >>> logic/bcs_cond_eval.sv
`timescale 1ns/1ps
// condition evaluator: flag selection, block or-ing, negation
module bcs_cond_eval
  import bcs_pkg::*;
#(
  parameter int unsigned NFLAGS = 32
) (
  input wire logic [NFLAGS-1:0] flags_x, // compute block x status
  input wire logic [NFLAGS-1:0] flags_y, // compute block y status
  input wire logic [NFLAGS-1:0] flags_int, // integer unit status
  input wire logic [NFLAGS-1:0] static_flags, // stored static flags
  input wire logic [4:0] sel, // flag index
  input wire logic [1:0] src, // 0 x,1 y,2 integer,3 static
  input wire logic any_blk, // block not named
  input wire logic neg, // negated condition
  output logic result // condition outcome
);
  logic raw;

  // unnamed compute condition ors both blocks
  always_comb
  begin
    case (src)
      2'h0: raw = any_blk ? (flags_x[sel] | flags_y[sel])
                          : flags_x[sel];
      2'h1: raw = flags_y[sel];
      2'h2: raw = flags_int[sel];
      default: raw = static_flags[sel];
    endcase
    result = raw ^ neg;
  end
endmodule

// >>> logic/bcs_axil_slave.sv
`timescale 1ns/1ps
// axi4-lite slave: handshakes, one write and one read in flight
module bcs_axil_slave
  import bcs_pkg::*;
(
  input wire logic clk, // core clock
  input wire logic rst_b, // async reset, active low
  input wire logic [7:0] awaddr, // write address
  input wire logic awvalid, // write address valid
  output logic awready, // write address ready
  input wire logic [31:0] wdata, // write data
  input wire logic [3:0] wstrb, // byte enables
  input wire logic wvalid, // write data valid
  output logic wready, // write data ready
  output logic [1:0] bresp, // write response
  output logic bvalid, // write response valid
  input wire logic bready, // write response ready
  input wire logic [7:0] araddr, // read address
  input wire logic arvalid, // read address valid
  output logic arready, // read address ready
  output logic [31:0] rdata, // read data
  output logic [1:0] rresp, // read response
  output logic rvalid, // read data valid
  input wire logic rready, // read data ready
  output logic wr_en, // register write pulse
  output logic [7:0] wr_addr, // register write address
  output logic [31:0] wr_data, // register write data
  output logic [3:0] wr_strb, // register byte enables
  input wire logic wr_ok, // address mapped
  output logic [7:0] rd_addr, // register read address
  input wire logic [31:0] rd_data, // register read data
  input wire logic rd_ok // read address mapped
);
  import bcs_pkg::*;

  typedef struct packed {
    logic aw_have;
    logic [7:0] aw;
    logic w_have;
    logic [31:0] w;
    logic [3:0] s;
    logic bv;
    logic [1:0] br;
    logic rv;
    logic [31:0] rd;
    logic [1:0] rr;
  } bcs_axs_t;

  bcs_axs_t st_q, st_d;

  assign awready = !st_q.aw_have && !st_q.bv;
  assign wready = !st_q.w_have && !st_q.bv;
  assign arready = !st_q.rv;
  assign bvalid = st_q.bv;
  assign bresp = st_q.br;
  assign rvalid = st_q.rv;
  assign rdata = st_q.rd;
  assign rresp = st_q.rr;
  assign wr_addr = st_q.aw;
  assign wr_data = st_q.w;
  assign wr_strb = st_q.s;
  assign wr_en = st_q.aw_have && st_q.w_have && !st_q.bv;
  assign rd_addr = araddr;

  // capture address and data in either order, then answer
  always_comb
  begin
    st_d = st_q;
    if (awvalid && awready)
    begin
      st_d.aw_have = 1'b1;
      st_d.aw = awaddr;
    end
    if (wvalid && wready)
    begin
      st_d.w_have = 1'b1;
      st_d.w = wdata;
      st_d.s = wstrb;
    end
    if (wr_en)
    begin
      st_d.aw_have = 1'b0;
      st_d.w_have = 1'b0;
      st_d.bv = 1'b1;
      st_d.br = wr_ok ? BCS_RESP_OKAY : BCS_RESP_SLVERR;
    end
    if (st_q.bv && bready)
      st_d.bv = 1'b0;
    if (arvalid && arready)
    begin
      st_d.rv = 1'b1;
      st_d.rd = rd_ok ? rd_data : 32'h0000_0000;
      st_d.rr = rd_ok ? BCS_RESP_OKAY : BCS_RESP_SLVERR;
    end
    else if (st_q.rv && rready)
      st_d.rv = 1'b0;
  end

  // state register
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      st_q <= '0;
    else
      st_q <= st_d;
  end
endmodule

// >>> logic/bcs_sequencer.sv
`timescale 1ns/1ps
// branch condition sequencer: predication, branches, control and status
//
// Behaviour
// - control bit one makes interrupt pin level-sensitive
// - control bit zero makes interrupt pin edge-sensitive
// - status bits 16-19 show sampled flag pin levels
// - direction bit one drives flag pin as output
// - one condition per line governs marked slots
// - conditional-do slots obey condition, others always run
// - else slots run only when branch not taken
// - unnamed block condition ors both compute blocks
// - sequencer instruction must sit in slot zero
// - targets over 16 bits use slot-one extension
// - static flag store holds flags for later conditions
// - call saves next line address, return uses it
// - computed call jumps to register, then saves return
// - relative targets from 32-bit pc, short absolute targets zero-extended
// - targets pc-relative unless absolute option given
// - conditional branch predicted unless not-predicted option
// - unconditional branch handled as predicted always-true
// - nop idle invalidate trap emulation-trap never predicated
module bcs_sequencer
  import bcs_pkg::*;
#(
  parameter int unsigned NFLAGS = 32
) (
  input wire logic clk, // core clock
  input wire logic rst_b, // async reset, active low
  input wire logic [7:0] awaddr, // axi write address
  input wire logic awvalid, // axi write address valid
  output logic awready, // axi write address ready
  input wire logic [31:0] wdata, // axi write data
  input wire logic [3:0] wstrb, // axi byte enables
  input wire logic wvalid, // axi write data valid
  output logic wready, // axi write data ready
  output logic [1:0] bresp, // axi write response
  output logic bvalid, // axi write response valid
  input wire logic bready, // axi write response ready
  input wire logic [7:0] araddr, // axi read address
  input wire logic arvalid, // axi read address valid
  output logic arready, // axi read address ready
  output logic [31:0] rdata, // axi read data
  output logic [1:0] rresp, // axi read response
  output logic rvalid, // axi read data valid
  input wire logic rready, // axi read data ready
  input wire bcs_pkg::bcs_line_t line_in, // decoded line
  input wire logic [1:0] cond_src, // condition source select
  input wire logic [NFLAGS-1:0] flags_x, // compute block x flags
  input wire logic [NFLAGS-1:0] flags_y, // compute block y flags
  input wire logic [NFLAGS-1:0] flags_int, // integer unit flags
  input wire logic static_we, // capture into static store
  input wire logic [NFLAGS-1:0] static_wdata, // flags to store
  input wire logic computed_jump_register_we, // integer unit loads jump register
  input wire logic [31:0] computed_jump_register_wdata, // computed jump address
  output bcs_pkg::bcs_result_t result, // line outcome
  input wire logic [3:0] irq_pin, // external interrupt pins
  output logic [3:0] irq_req, // interrupt requests
  input wire logic [3:0] irq_ack, // service of request
  input wire logic [3:0] gpio_in, // general signal pins input
  output logic [3:0] gpio_out, // general signal pins output
  output logic [3:0] gpio_oe // general signal pins enable
);
  import bcs_pkg::*;

  typedef struct packed {
    logic [31:0] control;
    logic [NFLAGS-1:0] static_flags;
    logic [31:0] computed_jump_register;
    logic [3:0] flg_in;
    logic [3:0] irq_prev;
    logic [3:0] irq_lat;
    logic [3:0] gpo;
    logic [3:0] gpoe;
    bcs_result_t res;
  } bcs_state_t;

  bcs_state_t st_q, st_d;
  logic wr_en;
  logic [7:0] wr_addr;
  logic [31:0] wr_data;
  logic [3:0] wr_strb;
  logic wr_ok;
  logic [7:0] rd_addr;
  logic [31:0] rd_data;
  logic rd_ok;
  logic cond_hit;
  logic [31:0] status_word;

  bcs_axil_slave u_axil (
    .clk(clk),
    .rst_b(rst_b),
    .awaddr(awaddr),
    .awvalid(awvalid),
    .awready(awready),
    .wdata(wdata),
    .wstrb(wstrb),
    .wvalid(wvalid),
    .wready(wready),
    .bresp(bresp),
    .bvalid(bvalid),
    .bready(bready),
    .araddr(araddr),
    .arvalid(arvalid),
    .arready(arready),
    .rdata(rdata),
    .rresp(rresp),
    .rvalid(rvalid),
    .rready(rready),
    .wr_en(wr_en),
    .wr_addr(wr_addr),
    .wr_data(wr_data),
    .wr_strb(wr_strb),
    .wr_ok(wr_ok),
    .rd_addr(rd_addr),
    .rd_data(rd_data),
    .rd_ok(rd_ok)
  );

  bcs_cond_eval #(
    .NFLAGS(NFLAGS)
  ) u_cond (
    .flags_x(flags_x),
    .flags_y(flags_y),
    .flags_int(flags_int),
    .static_flags(st_q.static_flags),
    .sel(line_in.cond_sel),
    .src(cond_src),
    .any_blk(line_in.cond_any_blk),
    .neg(line_in.cond_neg),
    .result(cond_hit)
  );

  // status word: flag pin levels in the upper half
  always_comb
  begin
    status_word = 32'h0000_0000;
    status_word[BCS_FLGIN_LSB +: BCS_NPINS] = st_q.flg_in;
  end

  // register read decode
  always_comb
  begin
    rd_ok = 1'b1;
    case (rd_addr)
      BCS_OFF_CONTROL: rd_data = st_q.control;
      BCS_OFF_STATUS: rd_data = status_word;
      BCS_OFF_STATIC: rd_data = 32'(st_q.static_flags);
      BCS_OFF_COMPUTED_JUMP_REGISTER: rd_data = st_q.computed_jump_register;
      default:
      begin
        rd_data = 32'h0000_0000;
        rd_ok = 1'b0;
      end
    endcase
  end

  assign wr_ok = (wr_addr == BCS_OFF_CONTROL) ||
                 (wr_addr == BCS_OFF_STATIC) ||
                 (wr_addr == BCS_OFF_COMPUTED_JUMP_REGISTER) ||
                 (wr_addr == BCS_OFF_STATUS);
  assign result = st_q.res;
  assign irq_req = st_q.irq_lat;
  assign gpio_out = st_q.gpo;
  assign gpio_oe = st_q.gpoe;

  // next state: registers, pins, line evaluation
  always_comb
  begin
    logic [31:0] wm;
    logic [31:0] imm;
    logic [31:0] tgt;
    logic [31:0] ret;
    logic is_branch;
    logic taken;
    logic always_op;
    logic use_cond;
    logic seq_line;
    logic bad;
    wm = 32'h0000_0000;
    imm = 32'h0000_0000;
    tgt = 32'h0000_0000;
    ret = 32'h0000_0000;
    is_branch = 1'b0;
    taken = 1'b0;
    always_op = 1'b0;
    use_cond = 1'b0;
    seq_line = 1'b0;
    bad = 1'b0;
    st_d = st_q;
    // software writes, byte enables honoured
    for (int b = 0; b < 4; b++)
      wm[b*8 +: 8] = {8{wr_strb[b]}};
    if (wr_en && wr_addr == BCS_OFF_CONTROL)
      st_d.control = (st_q.control & ~(wm & BCS_CONTROL_WMASK)) |
                     (wr_data & wm & BCS_CONTROL_WMASK);
    if (wr_en && wr_addr == BCS_OFF_STATIC)
      st_d.static_flags = NFLAGS'((32'(st_q.static_flags) & ~wm) |
                                  (wr_data & wm));
    if (wr_en && wr_addr == BCS_OFF_COMPUTED_JUMP_REGISTER)
      st_d.computed_jump_register = (st_q.computed_jump_register & ~wm) | (wr_data & wm);
    if (static_we)
      st_d.static_flags = static_wdata;
    if (computed_jump_register_we)
      st_d.computed_jump_register = computed_jump_register_wdata;
    // flag pins: direction and value
    st_d.gpoe = st_q.control[BCS_FLGDIR_LSB +: BCS_NPINS];
    st_d.gpo = st_q.control[BCS_FLGOUT_LSB +: BCS_NPINS];
    for (int p = 0; p < BCS_NPINS; p++)
      if (!st_q.control[BCS_FLGDIR_LSB + p])
        st_d.flg_in[p] = gpio_in[p];
    // interrupt pins: edge latches, level follows
    st_d.irq_prev = irq_pin;
    for (int p = 0; p < BCS_NPINS; p++)
    begin
      if (st_q.control[BCS_IRQ_LSB + p])
        st_d.irq_lat[p] = irq_pin[p];
      else if (irq_pin[p] && !st_q.irq_prev[p])
        st_d.irq_lat[p] = 1'b1;
      else if (irq_ack[p])
        st_d.irq_lat[p] = 1'b0;
    end
    // line evaluation
    always_op = (line_in.op == BCS_OP_NOP) || (line_in.op == BCS_OP_IDLE)
      || (line_in.op == BCS_OP_BINV) || (line_in.op == BCS_OP_TRAP)
      || (line_in.op == BCS_OP_ETRAP);
    seq_line = line_in.op != BCS_OP_NONE;
    bad = seq_line && (line_in.seq_slot != 4'h1);
    is_branch = (line_in.op == BCS_OP_JUMP) || (line_in.op == BCS_OP_CALL)
      || (line_in.op == BCS_OP_COMPUTED_JUMP_REGISTER) || (line_in.op == BCS_OP_CJCALL);
    use_cond = line_in.has_cond && !always_op;
    taken = use_cond ? cond_hit : 1'b1;
    imm = {16'h0000, line_in.imm_lo};
    if (line_in.ext_in_slot1)
      imm[31:BCS_SHORT_W] = line_in.imm_hi;
    else if (!line_in.abs_opt)
      imm[31:BCS_SHORT_W] = {16{line_in.imm_lo[BCS_SHORT_W-1]}};
    ret = line_in.pc + BCS_LINE_STEP;
    tgt = line_in.abs_opt ? imm : line_in.pc + imm;
    if (line_in.op == BCS_OP_COMPUTED_JUMP_REGISTER || line_in.op == BCS_OP_CJCALL)
      tgt = st_q.computed_jump_register;
    st_d.res = '0;
    st_d.res.valid = line_in.valid;
    if (line_in.valid && !bad)
    begin
      st_d.res.cond_true = taken;
      st_d.res.branch = is_branch && taken;
      st_d.res.target = tgt;
      st_d.res.predicted = is_branch &&
                           (!use_cond || !line_in.np_opt);
      for (int s = 0; s < BCS_NSLOTS; s++)
      begin
        if (!line_in.marked[s])
          st_d.res.slot_exec[s] = 1'b1;
        else if (is_branch)
          st_d.res.slot_exec[s] = !taken;
        else
          st_d.res.slot_exec[s] = taken;
      end
      st_d.res.idle = line_in.op == BCS_OP_IDLE;
      st_d.res.binv = line_in.op == BCS_OP_BINV;
      st_d.res.trap = line_in.op == BCS_OP_TRAP;
      st_d.res.etrap = line_in.op == BCS_OP_ETRAP;
      if (taken && (line_in.op == BCS_OP_CALL ||
                    line_in.op == BCS_OP_CJCALL))
        st_d.computed_jump_register = ret;
    end
    else if (line_in.valid)
      st_d.res.bad_line = 1'b1;
  end

  // state register
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      st_q <= '0;
      st_q.control <= BCS_CONTROL_RST;
    end
    else
      st_q <= st_d;
  end
endmodule

// >>> test/bcs_seq_sva.sv
// checker: port relations of the branch condition sequencer
`timescale 1ns/1ps
module bcs_seq_sva
  import bcs_pkg::*;
(
  input wire logic clk, // core clock
  input wire logic rst_b, // async reset, active low
  input wire logic arvalid, // read address valid
  input wire logic arready, // read address ready
  input wire logic rvalid, // read data valid
  input wire bcs_pkg::bcs_line_t line_in, // decoded line
  input wire bcs_pkg::bcs_result_t result, // line outcome
  input wire logic [3:0] irq_pin, // interrupt pins
  input wire logic [3:0] irq_req, // interrupt requests
  input wire logic [3:0] irq_ack // request service
);
  import bcs_pkg::*;

  logic [31:0] imm_d;
  logic [31:0] tgt_d;
  logic [31:0] tgt_q;
  logic ok_slot;
  logic is_br;

  // expected target of the line now offered
  always_comb
  begin
    imm_d = {{16{line_in.imm_lo[15]}}, line_in.imm_lo};
    if (line_in.abs_opt)
      imm_d = {16'h0000, line_in.imm_lo};
    if (line_in.ext_in_slot1)
      imm_d = {line_in.imm_hi, line_in.imm_lo};
    tgt_d = line_in.abs_opt ? imm_d : line_in.pc + imm_d;
  end

  // line outcome appears one cycle later, so keep the target
  always_ff @(posedge clk or negedge rst_b)
    if (!rst_b)
      tgt_q <= 32'h0000_0000;
    else
      tgt_q <= tgt_d;

  // well placed jump or call
  assign ok_slot = line_in.valid && line_in.seq_slot == 4'h1;
  assign is_br = line_in.op == BCS_OP_JUMP || line_in.op == BCS_OP_CALL;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_b);

  a_result_one_later: assert property (line_in.valid |=> result.valid)
    else $error("line gave no outcome");
  a_bad_slot_flag: assert property (
    line_in.valid && line_in.op != BCS_OP_NONE && line_in.seq_slot != 4'h1
    |=> result.bad_line && !result.branch)
    else $error("misplaced sequencer op not refused");
  a_plain_slots_run: assert property (
    line_in.valid && line_in.op == BCS_OP_NONE
    |=> (result.slot_exec | $past(line_in.marked)) == 4'hF)
    else $error("unmarked slot suppressed");
  a_marked_follow: assert property (
    line_in.valid && line_in.op == BCS_OP_NONE && line_in.has_cond
    |=> (result.slot_exec & $past(line_in.marked))
        == ($past(line_in.marked) & {4{result.cond_true}}))
    else $error("marked slot ignores condition");
  a_else_when_taken: assert property (
    ok_slot && line_in.op == BCS_OP_JUMP && line_in.has_cond
    |=> result.branch == result.cond_true
        && (result.slot_exec & $past(line_in.marked) & 4'hE)
        == (result.branch ? 4'h0 : $past(line_in.marked) & 4'hE))
    else $error("else slot wrong for branch outcome");
  a_predict_default: assert property (
    ok_slot && is_br
    |=> result.predicted
        == (!$past(line_in.has_cond) || !$past(line_in.np_opt)))
    else $error("prediction wrong");
  a_direct_target: assert property (
    ok_slot && is_br && !line_in.has_cond
    |=> result.branch && result.target == tgt_q)
    else $error("branch target wrong");
  a_irq_needs_pin: assert property (
    (irq_req & ~$past(irq_req) & ~$past(irq_pin)) == 4'h0)
    else $error("request rose without pin");
  a_irq_drop_cause: assert property (
    (~irq_req & $past(irq_req) & ~$past(irq_ack) & $past(irq_pin)) == 4'h0)
    else $error("request fell without cause");
  a_read_answer: assert property (arvalid && arready |=> rvalid)
    else $error("read not answered");

  c_call: cover property (ok_slot && line_in.op == BCS_OP_CALL);
  c_not_taken: cover property (result.valid && !result.branch && result.predicted == 1'b0);
  c_bad_line: cover property (result.bad_line);
endmodule

// >>> test/bcs_core_model.sv
// partner model: pipeline that issues lines and loads flags
`timescale 1ns/1ps
module bcs_core_model
  import bcs_pkg::*;
(
  input wire logic clk, // core clock
  output bcs_pkg::bcs_line_t line_in, // decoded line
  output logic [1:0] cond_src, // condition source
  output logic [31:0] flags_x, // block x flags
  output logic [31:0] flags_y, // block y flags
  output logic [31:0] flags_int, // integer flags
  output logic static_we, // static store load
  output logic [31:0] static_wdata, // static store value
  output logic computed_jump_register_we, // jump register load
  output logic [31:0] computed_jump_register_wdata, // jump register value
  input wire bcs_pkg::bcs_result_t result // line outcome
);
  import bcs_pkg::*;

  // quiet pipeline at time zero
  initial
  begin
    line_in = '0;
    cond_src = 2'h0;
    {flags_x, flags_y, flags_int} = '0;
    {static_we, computed_jump_register_we} = 2'h0;
    {static_wdata, computed_jump_register_wdata} = '0;
  end

  // one line for one cycle; outcome stands the next cycle
  task automatic issue(input bcs_line_t l, input logic [1:0] s,
                       output bcs_result_t r);
    @(posedge clk);
    line_in <= l;
    cond_src <= s;
    @(posedge clk);
    line_in.valid <= 1'b0;
    #1 r = result;
  endtask

  // one-cycle load: sel 0 static store, 1 jump register
  task automatic load(input logic sel, input logic [31:0] v);
    @(posedge clk);
    static_we <= !sel;
    computed_jump_register_we <= sel;
    static_wdata <= v;
    computed_jump_register_wdata <= v;
    @(posedge clk);
    static_we <= 1'b0;
    computed_jump_register_we <= 1'b0;
  endtask

  task automatic flags(input logic [31:0] x, y, i);
    @(posedge clk);
    flags_x <= x;
    flags_y <= y;
    flags_int <= i;
  endtask
endmodule

// >>> test/tb_branch_condition_sequencer.sv
// testbench: registers, pins and line outcomes of the sequencer
`timescale 1ns/1ps
module tb_branch_condition_sequencer;
  import bcs_pkg::*;
  logic clk, rst_b, static_we, computed_jump_register_we;
  logic awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready;
  logic [7:0] awaddr, araddr;
  logic [1:0] bresp, rresp, cond_src, rp;
  logic [3:0] wstrb, irq_pin, irq_req, irq_ack, gpio_in, gpio_out, gpio_oe;
  logic [31:0] wdata, rdata, computed_jump_register_wdata, v, flags_x, flags_y, flags_int;
  logic [31:0] static_wdata;
  logic [31:0] tg [4] = '{32'h0000_0FF0, 32'h0000_FFF0, 32'h1235_0FF0,
                          32'h1234_FFF0};
  bcs_op_t ops [5] = '{BCS_OP_NOP, BCS_OP_IDLE, BCS_OP_BINV, BCS_OP_TRAP,
                       BCS_OP_ETRAP};
  bcs_line_t line_in, l;
  bcs_result_t result, r;
  int n_mismatch, n_checks;

  bcs_sequencer #(.NFLAGS(32)) u_dut (.clk, .rst_b, .awaddr, .awvalid,
    .awready, .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready,
    .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready, .line_in,
    .cond_src, .flags_x, .flags_y, .flags_int, .static_we, .static_wdata,
    .computed_jump_register_we, .computed_jump_register_wdata, .result, .irq_pin, .irq_req, .irq_ack, .gpio_in,
    .gpio_out, .gpio_oe);
  bcs_core_model u_core (.clk, .line_in, .cond_src, .flags_x, .flags_y,
    .flags_int, .static_we, .static_wdata, .computed_jump_register_we, .computed_jump_register_wdata, .result);

  // core clock, 4 ns
  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_checks++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("FAIL t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  // handshakes sampled at the rising edge, released right after it
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
    logic aw, w, b;
    {aw, w, b} = 3'b110;
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    wstrb <= 4'hF;
    {awvalid, wvalid, bready} <= 3'b111;
    while (!b)
    begin
      @(posedge clk);
      if (awready) aw = 1'b0;
      if (wready) w = 1'b0;
      if (bvalid) b = 1'b1;
      rp = bresp;
      if (!aw) awvalid <= 1'b0;
      if (!w) wvalid <= 1'b0;
      if (b) bready <= 1'b0;
    end
  endtask

  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d);
    logic ar, done;
    {ar, done} = 2'b10;
    @(posedge clk);
    araddr <= a;
    {arvalid, rready} <= 2'b11;
    while (!done)
    begin
      @(posedge clk);
      if (arready) ar = 1'b0;
      if (rvalid) done = 1'b1;
      {d, rp} = {rdata, rresp};
      if (!ar) arvalid <= 1'b0;
      if (done) rready <= 1'b0;
    end
  endtask

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  function automatic bcs_line_t mk(bcs_op_t op, logic [31:0] pc,
                                   logic [15:0] im);
    mk = '0;
    mk.valid = 1'b1;
    mk.op = op;
    mk.pc = pc;
    mk.imm_lo = im;
    mk.seq_slot = (op == BCS_OP_NONE) ? 4'h0 : 4'h1;
  endfunction

  // whole run needs about 100 cycles
  initial
  begin
    #40000;
    n_mismatch++;
    tally_and_finish();
  end

  // main sequence
  initial
  begin
    {n_mismatch, n_checks} = '0;
    {rst_b, awvalid, wvalid, bready, arvalid, rready} = '0;
    {awaddr, araddr, wdata, wstrb} = '0;
    {irq_pin, irq_ack, gpio_in} = '0;
    repeat (8) @(posedge clk);
    rst_b <= 1'b1;
    axi_rd(BCS_OFF_CONTROL, v);
    chk(v, 32'h0000_0000);
    axi_wr(BCS_OFF_CONTROL, 32'hFFFF_FFFF);
    axi_rd(BCS_OFF_CONTROL, v);
    chk(v, 32'h0FFF_0000);
    chk(32'({gpio_oe, gpio_out}), 32'hFF);
    axi_wr(BCS_OFF_STATUS, 32'hFFFF_FFFF);
    chk(32'(rp), 32'(BCS_RESP_OKAY));
    axi_rd(8'h10, v);
    chk(32'(rp), 32'(BCS_RESP_SLVERR));
    axi_wr(BCS_OFF_CONTROL, 32'h0002_0000);
    gpio_in <= 4'hA;
    axi_rd(BCS_OFF_STATUS, v);
    chk(32'(v[19:16]), 32'hA);
    chk(32'(gpio_oe), 32'h0);
    $display("test registers done");
    irq_pin <= 4'h3;
    repeat (3) @(posedge clk);
    #1 chk(32'(irq_req), 32'h3);
    @(posedge clk);
    irq_pin <= 4'h0;
    repeat (3) @(posedge clk);
    #1 chk(32'(irq_req), 32'h1);
    @(posedge clk);
    irq_ack <= 4'h1;
    @(posedge clk);
    irq_ack <= 4'h0;
    repeat (2) @(posedge clk);
    #1 chk(32'(irq_req), 32'h0);
    $display("test interrupts done");
    u_core.load(1'b0, 32'h0000_0004);
    axi_rd(BCS_OFF_STATIC, v);
    chk(v, 32'h4);
    l = mk(BCS_OP_NONE, 32'h0, 16'h0);
    {l.has_cond, l.cond_sel, l.marked} = {1'b1, 5'd2, 4'hE};
    u_core.issue(l, 2'd3, r);
    chk(32'(r.slot_exec), 32'hF);
    l.cond_neg = 1'b1;
    u_core.issue(l, 2'd3, r);
    chk(32'(r.slot_exec), 32'h1);
    $display("test predication done");
    u_core.flags(32'h0, 32'h8, 32'h0);
    l = mk(BCS_OP_NONE, 32'h0, 16'h0);
    {l.has_cond, l.cond_sel, l.marked} = {1'b1, 5'd3, 4'hE};
    u_core.issue(l, 2'd1, r);
    chk(32'({r.cond_true, r.slot_exec}), 32'h1F);
    l = mk(BCS_OP_JUMP, 32'h100, 16'h0010);
    {l.has_cond, l.cond_sel, l.cond_any_blk, l.marked} = {7'h47, 4'hE};
    u_core.issue(l, 2'd0, r);
    chk(32'({r.branch, r.predicted, r.slot_exec & 4'hE}), 32'h30);
    chk(r.target, 32'h110);
    {l.cond_any_blk, l.np_opt} = 2'b01;
    u_core.issue(l, 2'd0, r);
    chk(32'({r.branch, r.predicted, r.slot_exec & 4'hE}), 32'h0E);
    for (int k = 0; k < 4; k++)
    begin
      l = mk(BCS_OP_JUMP, 32'h1000, 16'hFFF0);
      {l.ext_in_slot1, l.abs_opt, l.np_opt} = {k[1], k[0], 1'b1};
      l.imm_hi = 16'h1234;
      u_core.issue(l, 2'd2, r);
      chk(r.target, tg[k]);
      chk(32'({r.branch, r.predicted}), 32'h3);
    end
    $display("test branches done");
    u_core.issue(mk(BCS_OP_CALL, 32'h2000, 16'h0100), 2'd2, r);
    chk(r.target, 32'h2100);
    axi_rd(BCS_OFF_COMPUTED_JUMP_REGISTER, v);
    chk(v, 32'h2004);
    u_core.issue(mk(BCS_OP_COMPUTED_JUMP_REGISTER, 32'h2100, 16'h0), 2'd2, r);
    chk(r.target, 32'h2004);
    u_core.load(1'b1, 32'h3000);
    u_core.issue(mk(BCS_OP_CJCALL, 32'h4000, 16'h0), 2'd2, r);
    chk(r.target, 32'h3000);
    axi_rd(BCS_OFF_COMPUTED_JUMP_REGISTER, v);
    chk(v, 32'h4004);
    l = mk(BCS_OP_CALL, 32'h5000, 16'h0040);
    l.seq_slot = 4'h2;
    u_core.issue(l, 2'd2, r);
    chk(32'({r.bad_line, r.branch}), 32'h2);
    axi_rd(BCS_OFF_COMPUTED_JUMP_REGISTER, v);
    chk(v, 32'h4004);
    $display("test calls done");
    u_core.flags(32'h0, 32'h0, 32'h0);
    for (int k = 0; k < 5; k++)
    begin
      l = mk(ops[k], 32'h6000, 16'h0);
      l.has_cond = 1'b1;
      u_core.issue(l, 2'd2, r);
      v = 32'h10 | (32'h10 >> k);
      chk(32'({r.cond_true, r.idle, r.binv, r.trap, r.etrap}), v);
    end
    $display("test unconditional ops done");
    tally_and_finish();
  end
endmodule

bind bcs_sequencer bcs_seq_sva u_sva (.clk, .rst_b, .arvalid, .arready,
  .rvalid, .line_in, .result, .irq_pin, .irq_req, .irq_ack);
